// >>> rtl/see_consts.svh
`ifndef SEE_CONSTS_SVH
`define SEE_CONSTS_SVH

// Opcodes following the start bit
`define SEE_OP_SPECIAL      2'b00
`define SEE_OP_WRITE        2'b01
`define SEE_OP_READ         2'b10
`define SEE_OP_ERASE        2'b11

// Sub-commands in the two leading address bits of the special opcode
`define SEE_SUB_DISABLE     2'b00
`define SEE_SUB_WRITE_ALL   2'b01
`define SEE_SUB_ERASE_ALL   2'b10
`define SEE_SUB_ENABLE      2'b11

// Field lengths in bits
`define SEE_ADDR_BITS_X8    5'h09
`define SEE_ADDR_BITS_X16   5'h08
`define SEE_DATA_BITS_X8    5'h08
`define SEE_DATA_BITS_X16   5'h10

// Array shape and values
`define SEE_MEM_WORDS       128
`define SEE_ERASED_WORD     16'hffff
`define SEE_WEL_RESET       1'b0

// Timing
`define SEE_CLK_PERIOD_NS   40
`define SEE_MIN_DESELECT_NS 250
`define SEE_PROG_CYCLE_US   5000

`endif

// >>> rtl/see_engine.sv
// Overview of operation
// RULE1: Start bit one, then opcode 10 read, 11 erase, 01 write; 9/8 address bits.
// RULE2: Write carries 8 or 16 data bits after the address, MSB first.
// RULE3: Opcode 00 sub-commands: 11 enable, 00 disable, 10 erase all, 01 write all.
// RULE4: Write-all takes one data word stored into every location.
// RULE5: Host drives the unused top address bit to a definite level.
// RULE6: Read releases data out, sends one zero, then the word MSB first.
// RULE7: Read data bits change on the rising serial clock edge.
// RULE8: Continued clocking streams following words, wrapping to address zero.
// RULE9: Only the first word of a sequential read has the leading zero.
// RULE10: Write-enable latch is cleared at reset.
// RULE11: Erase and write instructions are ignored while the latch is cleared.
// RULE12: Latch stays set until the disable sub-command or reset.
// RULE13: Reads behave the same whatever the latch state.
// RULE14: Host lowers chip select after a full program instruction to launch it.
// RULE15: Chip select fall after write starts a self-timed clear and program cycle.
// RULE16: Write needs no preceding erase of the location.
// RULE17: Single erase leaves every bit of the location at one.
// RULE18: Erase-all sets every bit of the array to one in one cycle.
// RULE19: Write-all programs the data word into every location in one cycle.
// RULE20: Host may raise chip select during a cycle to poll data out.
// RULE21: Polled data out is low while busy and high once ready.
// RULE22: Start, opcode, address and data are sampled on rising serial clock.
// RULE23: Chip select stays low at least 0.25 us between instructions.
// RULE24: Each self-timed cycle ends within 5 ms, then status shows ready.
// RULE25: Chip select falling mid-instruction discards it and leaves memory unchanged.
// RULE26: Leading zeros are ignored while selected; the first one is the start bit.
`timescale 1ns/1ps
`include "see_consts.svh"

module see_engine #(
  parameter int unsigned PROG_CYCLES = `SEE_PROG_CYCLE_US * 1000 / `SEE_CLK_PERIOD_NS
) (
  input  wire logic clock_in,
  input  wire logic rst_in,
  input  wire logic chip_select_in,
  input  wire logic serial_clock_in,
  input  wire logic serial_data_in,
  input  wire logic organization_select_in,
  output logic      serial_data_out,
  output logic      serial_data_oe_out
);

  localparam int unsigned MIN_CS_CYCLES =
    (`SEE_MIN_DESELECT_NS + `SEE_CLK_PERIOD_NS - 1) / `SEE_CLK_PERIOD_NS;
  localparam logic [16:0] PROG_LAST = 17'(PROG_CYCLES - 1);
  localparam logic [3:0]  CS_MIN    = 4'(MIN_CS_CYCLES);

  // Word index of an address in either organization
  function automatic logic [6:0] word_of(input logic [8:0] a, input logic org16);
    word_of = org16 ? a[6:0] : a[7:1];
  endfunction : word_of

  // Byte lanes touched; in x8 the even byte is the high half
  function automatic logic [1:0] lane_of(input logic [8:0] a, input logic org16);
    lane_of = org16 ? 2'b11 : (a[0] ? 2'b01 : 2'b10);
  endfunction : lane_of

  see_mem_if mem_bus ();

  see_mem u_mem (
    .clock_in (clock_in),
    .rst_in   (rst_in),
    .mem_port (mem_bus.store)
  );

  // Pin synchronisers: {cs, sk, di, org}
  logic [3:0] pin_s1;
  logic [3:0] pin_s2;
  logic [3:0] pin_s3;
  logic [3:0] pin_f;
  logic [3:0] next_pin_f;
  logic       sk_q;
  logic       cs_q;

  // A change counts only once stages two and three agree
  always_comb begin
    next_pin_f = (pin_s2 & pin_s3) | (pin_f & (pin_s2 | pin_s3));
  end

  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      pin_s1 <= 4'h0;
      pin_s2 <= 4'h0;
      pin_s3 <= 4'h0;
      pin_f  <= 4'h0;
      sk_q   <= 1'b0;
      cs_q   <= 1'b0;
    end else begin
      pin_s1 <= {chip_select_in, serial_clock_in, serial_data_in, organization_select_in};
      pin_s2 <= pin_s1;
      pin_s3 <= pin_s2;
      pin_f  <= next_pin_f;
      sk_q   <= pin_f[2];
      cs_q   <= pin_f[3];
    end
  end

  logic cs;
  logic sk_rise;
  logic cs_fall;
  logic di;
  logic org16;
  assign cs      = pin_f[3];
  assign sk_rise = pin_f[2] & ~sk_q;
  assign cs_fall = ~pin_f[3] & cs_q;
  assign di      = pin_f[1];
  assign org16   = pin_f[0];

  // Deselect qualifier: a start bit counts only after a long enough low time
  logic [3:0] low_cnt;
  logic [3:0] next_low_cnt;
  logic       qual;
  logic       next_qual;

  always_comb begin
    next_low_cnt = cs ? 4'h0 : ((low_cnt == CS_MIN) ? low_cnt : low_cnt + 4'h1);
    next_qual    = cs ? qual : (next_low_cnt == CS_MIN); // RULE23
  end

  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      low_cnt <= 4'h0;
      qual    <= 1'b1;
    end else begin
      low_cnt <= next_low_cnt;
      qual    <= next_qual;
    end
  end

  // Command engine state
  see_pkg::see_state_type state, next_state;
  see_pkg::see_job_type   job, next_job;
  logic [4:0]  bit_cnt, next_bit_cnt;
  logic [1:0]  opcode, next_opcode;
  logic [8:0]  addr, next_addr;
  logic [15:0] wdat, next_wdat;
  logic [15:0] out_sh, next_out_sh;
  logic        dout, next_dout;
  logic        wel, next_wel;
  logic        poll, next_poll;
  logic        ready, next_ready;
  logic [16:0] prog_cnt, next_prog_cnt;
  logic        out_q, next_out_q;

  // Field lengths follow the organization pin
  logic [4:0]  alen;
  logic [4:0]  dlen;
  logic [8:0]  addr_in;
  logic [1:0]  sub;
  logic        addr_done;
  logic [15:0] rd_word;
  assign alen      = org16 ? `SEE_ADDR_BITS_X16 : `SEE_ADDR_BITS_X8; // RULE1
  assign dlen      = org16 ? `SEE_DATA_BITS_X16 : `SEE_DATA_BITS_X8; // RULE2
  assign addr_in   = {addr[7:0], di};
  assign sub       = org16 ? addr_in[7:6] : addr_in[8:7]; // RULE3
  assign addr_done = (bit_cnt == alen - 5'h01);
  assign rd_word   = org16 ? mem_bus.rd_data
                           : {(addr[0] ? mem_bus.rd_data[7:0] : mem_bus.rd_data[15:8]), 8'h00};

  // Partial instructions drop on cs fall; busy ignores the link
  always_comb begin
    next_state    = state;
    next_job      = job;
    next_bit_cnt  = bit_cnt;
    next_opcode   = opcode;
    next_addr     = addr;
    next_wdat     = wdat;
    next_out_sh   = out_sh;
    next_dout     = dout;
    next_wel      = wel;
    next_poll     = poll;
    next_prog_cnt = prog_cnt;
    if (state == see_pkg::S_BUSY) begin
      next_prog_cnt = prog_cnt + 17'h00001;
      if (prog_cnt == PROG_LAST) begin
        next_state = see_pkg::S_IDLE; // RULE24
      end
    end else if (cs_fall) begin
      if (state == see_pkg::S_WAIT_CS) begin
        next_state    = see_pkg::S_BUSY; // RULE14 RULE15
        next_prog_cnt = 17'h00000;
        next_poll     = 1'b1; // RULE20
      end else begin
        next_state = see_pkg::S_IDLE; // RULE25
      end
    end else if (cs && sk_rise) begin // RULE22
      unique case (state)
        see_pkg::S_IDLE: begin
          if (di && qual) begin // RULE26
            next_state   = see_pkg::S_OPCODE;
            next_bit_cnt = 5'h00;
            next_poll    = 1'b0;
          end
        end
        see_pkg::S_OPCODE: begin
          next_opcode = {opcode[0], di};
          if (bit_cnt == 5'h01) begin
            next_state   = see_pkg::S_ADDR;
            next_bit_cnt = 5'h00;
          end else begin
            next_bit_cnt = bit_cnt + 5'h01;
          end
        end
        see_pkg::S_ADDR: begin
          next_addr    = addr_in;
          next_bit_cnt = bit_cnt + 5'h01;
          if (addr_done) begin
            next_bit_cnt = 5'h00;
            unique case (opcode) // RULE1
              `SEE_OP_READ: begin
                next_state = see_pkg::S_READ; // RULE13
                next_dout  = 1'b0; // RULE6
              end
              `SEE_OP_ERASE: begin
                next_job   = see_pkg::JOB_ERASE;
                next_state = wel ? see_pkg::S_WAIT_CS : see_pkg::S_IGNORE; // RULE11
              end
              `SEE_OP_WRITE: begin
                next_job   = see_pkg::JOB_WRITE;
                next_state = see_pkg::S_DATA;
              end
              `SEE_OP_SPECIAL: begin
                unique case (sub) // RULE3
                  `SEE_SUB_ENABLE: begin
                    next_wel   = 1'b1;
                    next_state = see_pkg::S_IGNORE;
                  end
                  `SEE_SUB_DISABLE: begin
                    next_wel   = 1'b0; // RULE12
                    next_state = see_pkg::S_IGNORE;
                  end
                  `SEE_SUB_ERASE_ALL: begin
                    next_job   = see_pkg::JOB_ERASE_ALL;
                    next_state = wel ? see_pkg::S_WAIT_CS : see_pkg::S_IGNORE; // RULE11
                  end
                  `SEE_SUB_WRITE_ALL: begin
                    next_job   = see_pkg::JOB_WRITE_ALL; // RULE4
                    next_state = see_pkg::S_DATA;
                  end
                endcase
              end
            endcase
          end
        end
        see_pkg::S_DATA: begin
          next_wdat    = {wdat[14:0], di}; // RULE2
          next_bit_cnt = bit_cnt + 5'h01;
          if (bit_cnt == dlen - 5'h01) begin
            next_state = wel ? see_pkg::S_WAIT_CS : see_pkg::S_IGNORE; // RULE11
          end
        end
        see_pkg::S_READ: begin
          if (bit_cnt == 5'h00) begin
            // Next word loads straight after the last bit, no gap
            next_dout    = rd_word[15]; // RULE7 RULE9
            next_out_sh  = {rd_word[14:0], 1'b0};
            next_bit_cnt = dlen - 5'h01;
            next_addr    = org16 ? {2'b00, 7'(addr[6:0] + 7'h01)}
                                 : {1'b0, 8'(addr[7:0] + 8'h01)}; // RULE8
          end else begin
            next_dout    = out_sh[15]; // RULE7
            next_out_sh  = {out_sh[14:0], 1'b0};
            next_bit_cnt = bit_cnt - 5'h01;
          end
        end
        see_pkg::S_WAIT_CS, see_pkg::S_IGNORE, see_pkg::S_BUSY: begin
          next_state = state;
        end
      endcase
    end
    next_ready = (next_state != see_pkg::S_BUSY);
    // Pin level is registered so the status/data mux cannot glitch
    next_out_q = next_poll ? next_ready : next_dout; // RULE21
  end

  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      state    <= see_pkg::S_IDLE;
      job      <= see_pkg::JOB_ERASE;
      bit_cnt  <= 5'h00;
      opcode   <= 2'b00;
      addr     <= 9'h000;
      wdat     <= 16'h0000;
      out_sh   <= 16'h0000;
      dout     <= 1'b0;
      wel      <= `SEE_WEL_RESET; // RULE10
      poll     <= 1'b0;
      ready    <= 1'b1;
      prog_cnt <= 17'h00000;
      out_q    <= 1'b0;
    end else begin
      state    <= next_state;
      job      <= next_job;
      bit_cnt  <= next_bit_cnt;
      opcode   <= next_opcode;
      addr     <= next_addr;
      wdat     <= next_wdat;
      out_sh   <= next_out_sh;
      dout     <= next_dout;
      wel      <= next_wel;
      poll     <= next_poll;
      ready    <= next_ready;
      prog_cnt <= next_prog_cnt;
      out_q    <= next_out_q;
    end
  end

  // Array writes happen in the first cycles of the self-timed window
  always_comb begin
    mem_bus.rd_addr = word_of(addr, org16);
    mem_bus.wr_addr = word_of(addr, org16);
    mem_bus.wr_data = org16 ? wdat : {wdat[7:0], wdat[7:0]};
    mem_bus.wr_en   = 2'b00;
    if (state == see_pkg::S_BUSY) begin
      unique case (job)
        see_pkg::JOB_ERASE: begin
          mem_bus.wr_data = `SEE_ERASED_WORD; // RULE17
          mem_bus.wr_en   = (prog_cnt == 17'h00000) ? lane_of(addr, org16) : 2'b00;
        end
        see_pkg::JOB_WRITE: begin
          // Overwriting the lanes is the clear-then-program in one step
          mem_bus.wr_en = (prog_cnt == 17'h00000) ? lane_of(addr, org16) : 2'b00; // RULE16
        end
        see_pkg::JOB_ERASE_ALL, see_pkg::JOB_WRITE_ALL: begin
          if (job == see_pkg::JOB_ERASE_ALL) begin
            mem_bus.wr_data = `SEE_ERASED_WORD; // RULE18
          end
          if (prog_cnt < 17'(`SEE_MEM_WORDS)) begin
            mem_bus.wr_en   = 2'b11; // RULE19
            mem_bus.wr_addr = prog_cnt[6:0];
          end
        end
      endcase
    end
  end

  // Pin drive: status while polling, read data otherwise
  assign serial_data_out    = out_q; // RULE21
  assign serial_data_oe_out = cs && (poll || (state == see_pkg::S_READ)); // RULE6

  // Checks
  default clocking chk_clk @(posedge clock_in); endclocking
  default disable iff (rst_in);

  logic dis_hit;
  assign dis_hit = (state == see_pkg::S_ADDR) && cs && sk_rise && addr_done &&
                   (opcode == `SEE_OP_SPECIAL) && (sub == `SEE_SUB_DISABLE);

  chk_launch_busy: assert property ( // RULE15
    (state == see_pkg::S_WAIT_CS && cs_fall) |=> (state == see_pkg::S_BUSY && prog_cnt == 17'h0)
  ) else $error("program cycle not launched on cs fall");
  chk_cycle_end_ready: assert property ( // RULE24
    (state == see_pkg::S_BUSY && prog_cnt == PROG_LAST) |=> (state == see_pkg::S_IDLE && ready)
  ) else $error("program cycle did not end on time");
  chk_poll_busy_low: assert property ( // RULE21
    (state == see_pkg::S_BUSY && cs) |-> (serial_data_oe_out && !serial_data_out)
  ) else $error("busy status not shown low");
  chk_write_needs_wel: assert property ( // RULE11
    (mem_bus.wr_en != 2'b00) |-> wel
  ) else $error("array written with latch clear");
  chk_wel_clear_cause: assert property ( // RULE12
    $fell(wel) |-> $past(dis_hit)
  ) else $error("latch cleared without disable");
  chk_read_dummy_zero: assert property ( // RULE6
    (state == see_pkg::S_ADDR && next_state == see_pkg::S_READ) ##1 cs
      |-> (serial_data_oe_out && !serial_data_out)
  ) else $error("no leading zero before read data");
  chk_dout_on_rise: assert property ( // RULE7
    $changed(dout) |-> $past(sk_rise)
  ) else $error("read bit changed off a rising edge");
  chk_seq_wrap: assert property ( // RULE8
    (state == see_pkg::S_READ && cs && sk_rise && bit_cnt == 5'h00 && org16 &&
     addr[6:0] == 7'h7f) |=> (addr == 9'h000)
  ) else $error("sequential read did not wrap");
  chk_abort_partial: assert property ( // RULE25
    (cs_fall && state inside {see_pkg::S_OPCODE, see_pkg::S_ADDR, see_pkg::S_DATA})
      |=> (state == see_pkg::S_IDLE) [*2]
  ) else $error("partial instruction not discarded");
  chk_zero_ignored: assert property ( // RULE26
    (state == see_pkg::S_IDLE && cs && sk_rise && !di) |=> (state == see_pkg::S_IDLE)
  ) else $error("leading zero taken as start");
  chk_erase_ones: assert property ( // RULE17
    (state == see_pkg::S_BUSY && mem_bus.wr_en != 2'b00 &&
     (job == see_pkg::JOB_ERASE || job == see_pkg::JOB_ERASE_ALL))
      |-> (mem_bus.wr_data == `SEE_ERASED_WORD)
  ) else $error("erase data not all ones");

  cov_read_word: cover property (state == see_pkg::S_READ && sk_rise && bit_cnt == 5'h00);
  cov_write_launch: cover property (state == see_pkg::S_WAIT_CS && cs_fall &&
                                    job == see_pkg::JOB_WRITE);
  cov_erase_all: cover property (state == see_pkg::S_BUSY && job == see_pkg::JOB_ERASE_ALL);
  cov_poll_ready: cover property (poll && ready && cs);

endmodule : see_engine

// >>> rtl/see_mem.sv
`timescale 1ns/1ps
`include "see_consts.svh"

module see_mem (
  input  wire logic clock_in,
  input  wire logic rst_in,
  see_mem_if.store  mem_port
);

  logic [15:0] cells [0:`SEE_MEM_WORDS-1];
  logic [15:0] rd_q;
  logic [15:0] next_rd_q;

  // Array is nonvolatile storage, so it has no reset
  always_ff @(posedge clock_in) begin
    if (mem_port.wr_en[1]) begin
      cells[mem_port.wr_addr][15:8] <= mem_port.wr_data[15:8];
    end
    if (mem_port.wr_en[0]) begin
      cells[mem_port.wr_addr][7:0] <= mem_port.wr_data[7:0];
    end
  end

  // Registered read port
  always_comb begin
    next_rd_q = cells[mem_port.rd_addr];
  end

  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      rd_q <= 16'h0000;
    end else begin
      rd_q <= next_rd_q;
    end
  end

  assign mem_port.rd_data = rd_q;

endmodule : see_mem

// >>> rtl/see_mem_if.sv
`timescale 1ns/1ps

interface see_mem_if;
  logic [1:0]  wr_en;
  logic [6:0]  wr_addr;
  logic [15:0] wr_data;
  logic [6:0]  rd_addr;
  logic [15:0] rd_data;

  modport engine (output wr_en, output wr_addr, output wr_data, output rd_addr,
                  input rd_data);
  modport store  (input wr_en, input wr_addr, input wr_data, input rd_addr,
                  output rd_data);
endinterface : see_mem_if

// >>> rtl/see_pkg.sv
package see_pkg;

  // Command engine states
  typedef enum logic [2:0] {
    S_IDLE,
    S_OPCODE,
    S_ADDR,
    S_DATA,
    S_READ,
    S_WAIT_CS,
    S_IGNORE,
    S_BUSY
  } see_state_type;

  // Self-timed job waiting for the chip select fall
  typedef enum logic [1:0] {
    JOB_ERASE,
    JOB_WRITE,
    JOB_ERASE_ALL,
    JOB_WRITE_ALL
  } see_job_type;

endpackage : see_pkg

// >>> sim/see_host.sv
`timescale 1ns/1ps

module see_host (
  input  wire logic clock_in,
  input  wire logic dev_data_in,
  input  wire logic dev_oe_in,
  output logic      chip_select_out,
  output logic      serial_clock_out,
  output logic      serial_data_out
);
  // Idle link: deselected, serial clock parked low
  initial begin
    chip_select_out  = 1'b0;
    serial_clock_out = 1'b0;
    serial_data_out  = 1'b0;
  end

  // Deselect long enough to launch a cycle or separate instructions
  task automatic deselect();
    @(negedge clock_in);
    chip_select_out  <= 1'b0;
    serial_clock_out <= 1'b0;
    serial_data_out  <= ~serial_data_out; // No stale level on a released line
    repeat (11) @(negedge clock_in);
  endtask : deselect

  // One bit period of 8 clocks; returns the output left by the previous rise
  task automatic bit_io(input logic b, output logic r, output logic oe);
    @(negedge clock_in);
    chip_select_out  <= 1'b1;
    serial_clock_out <= 1'b0;
    serial_data_out  <= b;
    repeat (4) @(negedge clock_in);
    r  = dev_data_in;
    oe = dev_oe_in;
    serial_clock_out <= 1'b1;
    repeat (3) @(negedge clock_in);
  endtask : bit_io

  // Field sent most significant bit first
  task automatic send(input int n, input logic [15:0] v);
    logic r;
    logic oe;
    for (int i = n - 1; i >= 0; i--) begin
      bit_io(v[i], r, oe);
    end
  endtask : send

  // Poll status with the clock stopped; bounded so a stuck busy cannot hang
  task automatic wait_ready(output int n, output logic d0, output logic oe0);
    @(negedge clock_in);
    chip_select_out <= 1'b1;
    repeat (6) @(negedge clock_in);
    d0  = dev_data_in;
    oe0 = dev_oe_in;
    n   = 7;
    while (!(dev_oe_in === 1'b1 && dev_data_in === 1'b1) && n < 2000) begin
      @(negedge clock_in);
      n++;
    end
  endtask : wait_ready
endmodule : see_host

// >>> sim/serial_eeprom_command_engine_tb.sv
`timescale 1ns/1ps

module serial_eeprom_command_engine_tb;
  localparam int unsigned PROG  = 300;
  localparam int          LIMIT = 40000;

  logic clock_in   = 1'b0;
  logic rst_in     = 1'b1;
  logic organization_select        = 1'b1;
  logic cs;
  logic sk;
  logic di;
  logic dout;
  logic doe;
  int   err_count  = 0;
  int   num_checks = 0;
  int   cycles     = 0;

  // 25 MHz system clock
  always #20 clock_in = ~clock_in;

  see_engine #(.PROG_CYCLES(PROG)) i_dut (
    .clock_in(clock_in), .rst_in(rst_in), .chip_select_in(cs), .serial_clock_in(sk),
    .serial_data_in(di), .organization_select_in(organization_select), .serial_data_out(dout),
    .serial_data_oe_out(doe));

  see_host i_host (
    .clock_in(clock_in), .dev_data_in(dout), .dev_oe_in(doe), .chip_select_out(cs),
    .serial_clock_out(sk), .serial_data_out(di));

  task automatic print_verdict();
    $display("checks=%0d errors=%0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : print_verdict

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  // Field widths follow the organization pin
  function automatic int ab();
    return organization_select ? 8 : 9;
  endfunction : ab

  function automatic int db();
    return organization_select ? 16 : 8;
  endfunction : db

  function automatic logic [8:0] sub(input logic [1:0] s);
    return organization_select ? {1'b0, s, 6'h00} : {s, 7'h00};
  endfunction : sub

  task automatic instr(input logic [1:0] op, input logic [8:0] a, input logic [15:0] d,
                       input bit wd, input int lead);
    i_host.deselect();
    i_host.send(lead, 16'h0000);
    i_host.send(3, {13'h0000, 1'b1, op});
    i_host.send(ab(), {7'h00, a});
    if (wd) begin
      i_host.send(db(), d);
    end
  endtask : instr

  // Launch by deselect, then poll busy to ready
  task automatic launch(input logic [1:0] op, input logic [8:0] a, input logic [15:0] d,
                        input bit wd);
    int   n;
    logic d0;
    logic oe0;
    instr(op, a, d, wd, 0);
    i_host.deselect();
    i_host.wait_ready(n, d0, oe0);
    check(16'({oe0, d0}), 16'h0002);
    check(16'(n >= PROG - 40 && n <= PROG), 16'h0001);
  endtask : launch

  // Two words of a sequential read
  task automatic readw(input logic [8:0] a, input int lead, input logic [15:0] e0,
                       input logic [15:0] e1);
    logic        r;
    logic        oe;
    logic [15:0] w;
    instr(2'b10, a, 16'h0000, 1'b0, lead);
    i_host.bit_io(1'b0, r, oe);
    check(16'({oe, r}), 16'h0002);
    for (int k = 0; k < 2; k++) begin
      w = 16'h0000;
      for (int i = 0; i < db(); i++) begin
        i_host.bit_io(1'b0, r, oe);
        w = {w[14:0], r};
      end
      check(w, k == 0 ? e0 : e1);
    end
  endtask : readw

  // Latch protection across disable and a reset in mid-run
  task automatic t_protect();
    instr(2'b00, sub(2'b11), 16'h0000, 1'b0, 0);
    launch(2'b01, 9'h003, 16'h1234, 1'b1);
    launch(2'b01, 9'h004, 16'habcd, 1'b1);
    instr(2'b00, sub(2'b00), 16'h0000, 1'b0, 0);
    instr(2'b01, 9'h003, 16'h5555, 1'b1, 0);
    i_host.deselect();
    readw(9'h003, 0, 16'h1234, 16'habcd);
    @(negedge clock_in);
    rst_in <= 1'b1;
    repeat (5) @(negedge clock_in);
    rst_in <= 1'b0;
    instr(2'b11, 9'h004, 16'h0000, 1'b0, 0);
    i_host.deselect();
    readw(9'h003, 2, 16'h1234, 16'habcd);
  endtask : t_protect

  // Overwrite without erase, then single erase
  task automatic t_erase();
    instr(2'b00, sub(2'b11), 16'h0000, 1'b0, 0);
    launch(2'b01, 9'h083, 16'h00ff, 1'b1);
    launch(2'b11, 9'h004, 16'h0000, 1'b0);
    readw(9'h003, 0, 16'h00ff, 16'hffff);
  endtask : t_erase

  // Whole-array commands and the wrap at the top address
  task automatic t_all();
    launch(2'b00, sub(2'b01), 16'h5a5a, 1'b1);
    launch(2'b01, 9'h000, 16'h0f0f, 1'b1);
    readw(9'h07f, 0, 16'h5a5a, 16'h0f0f);
    launch(2'b00, sub(2'b10), 16'h0000, 1'b0);
    readw(9'h000, 0, 16'hffff, 16'hffff);
  endtask : t_all

  // Byte mode, ignored top bit, and an instruction cut short
  task automatic t_byte();
    organization_select <= 1'b0;
    launch(2'b01, 9'h105, 16'h00c3, 1'b1);
    readw(9'h004, 0, 16'h00ff, 16'h00c3);
    instr(2'b01, 9'h004, 16'h0000, 1'b0, 0);
    i_host.send(5, 16'h0000);
    i_host.deselect();
    readw(9'h004, 0, 16'h00ff, 16'h00c3);
  endtask : t_byte

  // Main sequence
  initial begin
    repeat (5) @(negedge clock_in);
    rst_in <= 1'b0;
    t_protect();
    t_erase();
    t_all();
    t_byte();
    print_verdict();
  end

  // Hang guard, well above the expected run length
  always @(posedge clock_in) begin
    cycles++;
    if (cycles == LIMIT) begin
      err_count++;
      print_verdict();
    end
  end
endmodule : serial_eeprom_command_engine_tb
